/* File: common/uctl_defs.vh */
// Constants for the serial control register block.
`ifndef UCTL_DEFS_VH
`define UCTL_DEFS_VH
`define UCTL_ADDR_W        4
`define UCTL_OFS_CTRL2     4'h0
`define UCTL_OFS_STATUS    4'h4
`define UCTL_OFS_EVENT     4'h8
`define UCTL_OFS_MASK      4'hC
`define UCTL_CTRL2_RESET   8'h00
`define UCTL_BIT_TXE_IE    7
`define UCTL_BIT_TXD_IE    6
`define UCTL_BIT_RXF_IE    5
`define UCTL_BIT_IDL_IE    4
`define UCTL_BIT_TX_ON     3
`define UCTL_BIT_RX_ON     2
`define UCTL_EV_W          6
`define UCTL_EV_RESET      6'h00
`define UCTL_EV_TXE        0
`define UCTL_EV_TXD        1
`define UCTL_EV_RXF        2
`define UCTL_EV_IDL        3
`define UCTL_EV_QIDLE      4
`define UCTL_EV_REL        5
`define UCTL_ST_TXE        0
`define UCTL_ST_TXD        1
`define UCTL_ST_RXF        2
`define UCTL_ST_IDL        3
`define UCTL_ST_TXOWN      4
`define UCTL_ST_DRAIN      5
`define UCTL_ST_RXOWN      6
`define UCTL_ST_BUSY       7
`define UCTL_TXS_W         2
`define UCTL_TXS_OFF       2'h0
`define UCTL_TXS_ON        2'h1
`define UCTL_TXS_DRAIN     2'h2
`define UCTL_WORD_ZERO     32'h0000_0000
`define UCTL_WORD_W        32
`define UCTL_REG_W         8
`define UCTL_PIN_IDLE      1'b1
`define UCTL_OE_N_OFF      1'b1
`define UCTL_FLAGS_RESET   4'h0
`define UCTL_STATUS_RESET  8'h00
`endif

/* File: core/uctl_sync2.v */
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
module uctl_sync2 #(
   parameter W    = 1,
   parameter INIT = 1'b1
) (
   input  wire         ref_clk,
   input  wire         rst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] stage1;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage1 <= {W{INIT}};
         dout   <= {W{INIT}};
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule // uctl_sync2

/* File: core/uctl_sticky.v */
// Sticky event bits; a set in the same cycle as a clear wins.
`timescale 1ns/100ps
module uctl_sticky #(
   parameter W = 1
) (
   input  wire         ref_clk,
   input  wire         rst,
   input  wire [W-1:0] set,
   input  wire [W-1:0] clr,
   output reg  [W-1:0] q
);
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= {W{1'b0}};
      end else begin
         q <= (q & ~clr) | set;
      end
   end
endmodule // uctl_sticky

/* File: core/uctl_top.v */
// Second serial control register, pin ownership and interrupt logic.
//
// Overview of operation
// - Transmit-empty enable gates empty flag interrupt.
// - Done enable gates transmission-complete flag interrupt.
// - Receive-full enable gates full flag interrupt.
// - Idle enable gates idle line flag interrupt.
// - Transmitter runs only while enable bit set.
// - Enabled transmitter drives transmit pin, overriding port.
// - Loop without source select returns pin to port.
// - Single-wire direction bit decides transmit pin direction.
// - Off-then-on during transmission queues one idle.
// - After disable, keep pin until pending traffic ends.
// - Receiver enable; when off, receive pin to port.
// - Register access never blocked by link activity.
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`include "uctl_defs.vh"
module uctl_top (
   input  wire                    ref_clk,
   input  wire                    rst,
   input  wire [`UCTL_ADDR_W-1:0] avs_address,
   input  wire                    avs_read,
   input  wire                    avs_write,
   input  wire [31:0]             avs_writedata,
   input  wire [3:0]              avs_byteenable,
   output reg  [31:0]             avs_readdata,
   output wire                    avs_waitrequest,
   input  wire                    tx_buffer_empty_flag,
   input  wire                    tx_done_flag,
   input  wire                    rx_full_flag,
   input  wire                    idle_line_flag,
   input  wire                    tx_busy,
   input  wire                    tx_serial,
   input  wire                    loop_mode_select,
   input  wire                    rx_source_select,
   input  wire                    single_wire_direction,
   input  wire                    port_txd_out,
   input  wire                    port_txd_dir,
   input  wire                    txd_pin_in,
   output reg                     txd_pin_out,
   output reg                     txd_pin_oe_n,
   input  wire                    rxd_pin_in,
   output reg                     rx_serial,
   output wire                    tx_run,
   output wire                    rx_run,
   output reg                     tx_queue_idle,
   output wire                    txd_port_owned,
   output wire                    rxd_port_owned,
   output wire                    irq
);

   // Transmitter ownership states.
   localparam [`UCTL_TXS_W-1:0] TXS_OFF   = `UCTL_TXS_OFF;
   localparam [`UCTL_TXS_W-1:0] TXS_ON    = `UCTL_TXS_ON;
   localparam [`UCTL_TXS_W-1:0] TXS_DRAIN = `UCTL_TXS_DRAIN;

   // Control register and transmitter ownership state.
   reg  [7:0]                uart_control_2;
   reg  [`UCTL_TXS_W-1:0]    tx_state;
   reg  [`UCTL_TXS_W-1:0]    next_tx_state;
   reg                       next_queue_idle;
   reg                       ack;
   reg  [3:0]                flag_prev;
   reg  [`UCTL_EV_W-1:0]     event_mask;
   wire [`UCTL_EV_W-1:0]     event_status;
   wire [`UCTL_EV_W-1:0]     event_set;
   wire [`UCTL_EV_W-1:0]     event_clr;
   wire [3:0]                flags;
   wire [3:0]                flag_enables;
   wire                      txd_sync;
   wire                      rxd_sync;
   wire                      req;
   wire                      wr_fire;
   wire                      rd_take;
   wire                      wr_ctrl;
   wire                      new_tx_on;
   wire                      tx_on;
   wire                      rx_on;
   wire                      tx_hold;
   wire                      tx_owns;
   wire                      loop_to_port;
   wire                      single_wire;
   wire                      drive_tx;
   wire                      released;
   reg  [7:0]                status_view;

   uctl_sync2 #(
      .W    (1),
      .INIT (`UCTL_PIN_IDLE)
   ) u_txd_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (txd_pin_in),
      .dout    (txd_sync)
   );

   uctl_sync2 #(
      .W    (1),
      .INIT (`UCTL_PIN_IDLE)
   ) u_rxd_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .din     (rxd_pin_in),
      .dout    (rxd_sync)
   );

   // Every access takes exactly one wait state, whatever the link does.
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack;
   assign wr_fire         = avs_write & ack & avs_byteenable[0];
   assign rd_take         = avs_read & ~ack;
   assign wr_ctrl         = wr_fire & (avs_address == `UCTL_OFS_CTRL2);
   assign new_tx_on       = avs_writedata[`UCTL_BIT_TX_ON];

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         uart_control_2 <= `UCTL_CTRL2_RESET;
      end else if (wr_ctrl) begin
         uart_control_2 <= avs_writedata[7:0];
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         event_mask <= `UCTL_EV_RESET;
      end else if (wr_fire && avs_address == `UCTL_OFS_MASK) begin
         event_mask <= avs_writedata[`UCTL_EV_W-1:0];
      end
   end

   assign tx_on = uart_control_2[`UCTL_BIT_TX_ON];
   assign rx_on = uart_control_2[`UCTL_BIT_RX_ON];
   assign tx_run = tx_on;
   assign rx_run = rx_on;

   // The drain state keeps the pin after a disable until the engine
   // reports that data, queued idle or queued break have gone out.
   always @* begin
      next_tx_state   = tx_state;
      next_queue_idle = 1'b0;
      case (tx_state)
         TXS_OFF: begin
            if (wr_ctrl && new_tx_on) begin
               next_tx_state = TXS_ON;
            end
         end
         TXS_ON: begin
            if (wr_ctrl && !new_tx_on) begin
               if (tx_busy) begin
                  next_tx_state = TXS_DRAIN;
               end else begin
                  next_tx_state = TXS_OFF;
               end
            end
         end
         TXS_DRAIN: begin
            if (wr_ctrl && new_tx_on) begin
               next_tx_state   = TXS_ON;
               next_queue_idle = tx_busy;
            end else if (!tx_busy) begin
               next_tx_state = TXS_OFF;
            end
         end
         default: begin
            next_tx_state = TXS_OFF;
         end
      endcase
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_state      <= TXS_OFF;
         tx_queue_idle <= 1'b0;
      end else begin
         tx_state      <= next_tx_state;
         tx_queue_idle <= next_queue_idle;
      end
   end

   assign tx_hold  = (tx_state == TXS_DRAIN);
   assign released = tx_hold & (next_tx_state == TXS_OFF);

   // Pin ownership and direction.
   assign loop_to_port = loop_mode_select & ~rx_source_select;
   assign single_wire  = loop_mode_select & rx_source_select;
   assign tx_owns      = (tx_on | tx_hold) & ~loop_to_port;
   assign drive_tx     = single_wire ? single_wire_direction : 1'b1;
   assign txd_port_owned = ~tx_owns;
   assign rxd_port_owned = ~rx_on;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txd_pin_out  <= `UCTL_PIN_IDLE;
         txd_pin_oe_n <= `UCTL_OE_N_OFF;
      end else if (tx_owns) begin
         txd_pin_out  <= tx_serial;
         txd_pin_oe_n <= ~drive_tx;
      end else begin
         txd_pin_out  <= port_txd_out;
         txd_pin_oe_n <= ~port_txd_dir;
      end
   end

   // Receive data source follows the loop and single-wire selection.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_serial <= `UCTL_PIN_IDLE;
      end else if (!rx_on) begin
         rx_serial <= `UCTL_PIN_IDLE;
      end else if (single_wire) begin
         rx_serial <= txd_sync;
      end else if (loop_mode_select) begin
         rx_serial <= tx_serial;
      end else begin
         rx_serial <= rxd_sync;
      end
   end

   // Flag order matches the status and event layout.
   assign flags = {idle_line_flag, rx_full_flag,
                   tx_done_flag, tx_buffer_empty_flag};
   assign flag_enables = {uart_control_2[`UCTL_BIT_IDL_IE],
                          uart_control_2[`UCTL_BIT_RXF_IE],
                          uart_control_2[`UCTL_BIT_TXD_IE],
                          uart_control_2[`UCTL_BIT_TXE_IE]};

   // A flag already high when reset ends counts as a rising edge.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flag_prev <= `UCTL_FLAGS_RESET;
      end else begin
         flag_prev <= flags;
      end
   end

   // The sticky cells let a new event win over a clear in one cycle.
   assign event_set = {released, next_queue_idle, flags & ~flag_prev};
   assign event_clr = (wr_fire && avs_address == `UCTL_OFS_EVENT) ?
                      avs_writedata[`UCTL_EV_W-1:0] : `UCTL_EV_RESET;

   uctl_sticky #(
      .W (`UCTL_EV_W)
   ) u_events (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set     (event_set),
      .clr     (event_clr),
      .q       (event_status)
   );

   // Level requests follow the live flags; sticky events add to them.
   assign irq = (|(flags & flag_enables))
              | (|(event_status & event_mask));

   // Status bits sit at their named positions.
   always @* begin
      status_view                 = `UCTL_STATUS_RESET;
      status_view[`UCTL_ST_TXE]   = tx_buffer_empty_flag;
      status_view[`UCTL_ST_TXD]   = tx_done_flag;
      status_view[`UCTL_ST_RXF]   = rx_full_flag;
      status_view[`UCTL_ST_IDL]   = idle_line_flag;
      status_view[`UCTL_ST_TXOWN] = tx_owns;
      status_view[`UCTL_ST_DRAIN] = tx_hold;
      status_view[`UCTL_ST_RXOWN] = rx_on & ~rxd_port_owned;
      status_view[`UCTL_ST_BUSY]  = tx_busy;
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= `UCTL_WORD_ZERO;
      end else if (rd_take) begin
         case (avs_address)
            `UCTL_OFS_CTRL2: begin
               avs_readdata <= {{(`UCTL_WORD_W-`UCTL_REG_W){1'b0}},
                                uart_control_2};
            end
            `UCTL_OFS_STATUS: begin
               avs_readdata <= {{(`UCTL_WORD_W-`UCTL_REG_W){1'b0}},
                                status_view};
            end
            `UCTL_OFS_EVENT: begin
               avs_readdata <= {{(`UCTL_WORD_W-`UCTL_EV_W){1'b0}},
                                event_status};
            end
            `UCTL_OFS_MASK: begin
               avs_readdata <= {{(`UCTL_WORD_W-`UCTL_EV_W){1'b0}},
                                event_mask};
            end
            default: begin
               avs_readdata <= `UCTL_WORD_ZERO;
            end
         endcase
      end
   end

endmodule // uctl_top

/* File: bench/uctl_monitor.sv */
// Port checker for the serial control register block.
`timescale 1ns/100ps
module uctl_monitor (
   input logic ref_clk,
   input logic rst,
   input logic avs_read,
   input logic avs_write,
   input logic avs_waitrequest,
   input logic tx_busy,
   input logic tx_serial,
   input logic loop_mode_select,
   input logic rx_source_select,
   input logic single_wire_direction,
   input logic port_txd_dir,
   input logic txd_pin_out,
   input logic txd_pin_oe_n,
   input logic rx_serial,
   input logic tx_run,
   input logic rx_run,
   input logic tx_queue_idle,
   input logic txd_port_owned,
   input logic rxd_port_owned
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("access delayed");
   property p_drive;
      !txd_port_owned && !loop_mode_select
         |=> !txd_pin_oe_n && txd_pin_out == $past(tx_serial);
   endproperty
   a_drive: assert property (p_drive) else $error("pin not driven");
   property p_loop;
      loop_mode_select && !rx_source_select |-> txd_port_owned;
   endproperty
   a_loop: assert property (p_loop) else $error("loop pin owned");
   property p_port;
      txd_port_owned |=> txd_pin_oe_n == !$past(port_txd_dir);
   endproperty
   a_port: assert property (p_port) else $error("port dir lost");
   property p_single;
      !txd_port_owned && loop_mode_select && rx_source_select
         |=> txd_pin_oe_n == !$past(single_wire_direction);
   endproperty
   a_single: assert property (p_single) else $error("wire dir");
   property p_qidle;
      tx_queue_idle |-> tx_run ##1 !tx_queue_idle;
   endproperty
   a_qidle: assert property (p_qidle) else $error("idle pulse");
   property p_hold;
      !txd_port_owned && tx_busy && !loop_mode_select ##1 !loop_mode_select
         |-> !txd_port_owned;
   endproperty
   a_hold: assert property (p_hold) else $error("pin lost early");
   property p_off;
      !tx_run && !tx_busy ##1 !tx_run && !tx_busy |-> txd_port_owned;
   endproperty
   a_off: assert property (p_off) else $error("pin kept");
   property p_rx;
      !rx_run ##1 !rx_run |-> rxd_port_owned && rx_serial;
   endproperty
   a_rx: assert property (p_rx) else $error("receiver off");
endmodule // uctl_monitor
bind uctl_top uctl_monitor mon (.ref_clk, .rst, .avs_read, .avs_write,
   .avs_waitrequest, .tx_busy, .tx_serial, .loop_mode_select,
   .rx_source_select, .single_wire_direction, .port_txd_dir, .txd_pin_out,
   .txd_pin_oe_n, .rx_serial, .tx_run, .rx_run, .tx_queue_idle,
   .txd_port_owned, .rxd_port_owned);

/* File: bench/uctl_remote.sv */
// Remote serial sender, eight clocks a bit, idle high.
`timescale 1ns/100ps
module uctl_remote (
   input  logic       ref_clk,
   input  logic       go,
   input  logic [7:0] data,
   output logic       rxd,
   output logic       mid
);
   logic [9:0] sh = 10'h3FF;
   logic [6:0] n = 7'h00;
   initial mid = 1'b0;
   assign rxd = sh[0];
   always @(posedge ref_clk) begin
      mid <= n != 7'h00 && n[2:0] == 3'h4;
      if (go) begin
         sh <= {1'b1, data, 1'b0};
         n <= 7'h50;
      end else if (n != 7'h00) begin
         n <= n - 7'h01;
         if (n[2:0] == 3'h1) sh <= {1'b1, sh[9:1]};
      end
   end
endmodule // uctl_remote

/* File: bench/uctl_top_bench.sv */
// Self-checking bench for the serial control register block.
`timescale 1ns/100ps
module uctl_top_bench;
   logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, go = 0;
   logic [3:0] avs_address = 0, fl = 0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 0;
   logic tx_busy = 0, tx_serial = 1, loop_mode_select = 0, mid;
   logic rx_source_select = 0, single_wire_direction = 0, rxd_pin_in;
   logic port_txd_out = 0, port_txd_dir = 0;
   logic [7:0] b, c, d;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, txd_pin_out, txd_pin_oe_n, rx_serial, tx_run, irq;
   wire rx_run, tx_queue_idle, txd_port_owned, rxd_port_owned;
   wire tx_buffer_empty_flag = fl[3], tx_done_flag = fl[2];
   wire rx_full_flag = fl[1], idle_line_flag = fl[0];
   wire txd_pin_in = txd_pin_oe_n ? 1'b1 : txd_pin_out;
   int num_errors = 0, num_checks = 0, i, k, q;
   uctl_top dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .tx_buffer_empty_flag, .tx_done_flag, .rx_full_flag, .idle_line_flag,
      .tx_busy, .tx_serial, .loop_mode_select, .rx_source_select,
      .single_wire_direction, .port_txd_out, .port_txd_dir, .txd_pin_in,
      .txd_pin_out, .txd_pin_oe_n, .rxd_pin_in, .rx_serial, .tx_run,
      .rx_run, .tx_queue_idle, .txd_port_owned, .rxd_port_owned, .irq);
   uctl_remote far (.ref_clk, .go, .data(b), .rxd(rxd_pin_in), .mid);
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (!rst) q <= q + tx_queue_idle;
   end
   function automatic logic exp_irq(input logic [7:0] ctl, logic [3:0] f);
      return |(ctl[7:4] & f);
   endfunction
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic acc(input logic w, logic [3:0] a, logic [7:0] v);
      avs_address <= a;
      avs_writedata <= {24'h00_0000, v};
      avs_write <= w;
      avs_read <= !w;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (avs_waitrequest && k < 20);
      d = avs_readdata[7:0];
      avs_write <= 0;
      avs_read <= 0;
      if (k == 20) begin
         num_errors++;
         test_done;
      end
      @(posedge ref_clk);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   initial begin
      void'($urandom(32'hf59794e8));
      tick(10);
      rst <= 0;
      tick(1);
      acc(0, 4'h0, 0); chk(d, 8'h00);
      acc(0, 4'h2, 0); chk(d, 8'h00);
      avs_byteenable <= 4'hE;
      acc(1, 4'h0, 8'hFF);
      avs_byteenable <= 4'hF;
      acc(0, 4'h0, 0); chk(d, 8'h00);
      for (i = 0; i < 24; i++) begin
         c = $urandom & 8'hF0;
         acc(1, 4'h0, c);
         fl <= $urandom;
         acc(0, 4'h0, 0); chk(d, c);
         chk(irq, exp_irq(c, fl));
      end
      acc(1, 4'h0, 0);
      fl <= 0;
      acc(1, 4'h8, 8'h3F);
      acc(1, 4'hC, 8'h01);
      fl <= 4'h8;
      tick(3); chk(irq, 1);
      fl <= 0;
      acc(1, 4'h8, 8'h01);
      tick(1); chk(irq, 0);
      acc(1, 4'hC, 8'h00);
      tx_busy <= 1;
      acc(1, 4'h0, 8'h08);
      chk(tx_run, 1);
      for (i = 0; i < 6; i++) begin
         tx_serial <= $urandom;
         tick(2); chk(txd_pin_out, tx_serial);
      end
      acc(1, 4'h0, 8'h00);
      tick(1); chk(txd_port_owned, 0);
      acc(0, 4'h4, 0); chk(d, 8'hB0);
      chk(q, 0);
      acc(1, 4'h0, 8'h08);
      tick(1); chk(q, 1);
      acc(1, 4'h0, 8'h00);
      tick(5); chk(txd_pin_oe_n, 0);
      tx_busy <= 0;
      tick(3); chk(txd_port_owned, 1);
      chk(q, 1);
      acc(1, 4'h0, 8'h08);
      port_txd_out <= 1;
      tx_serial <= 0;
      loop_mode_select <= 1;
      tick(3); chk(txd_port_owned, 1);
      chk(txd_pin_oe_n, 1);
      chk(txd_pin_out, 1);
      rx_source_select <= 1;
      for (i = 0; i < 4; i++) begin
         single_wire_direction <= i[0];
         tick(3); chk(txd_pin_oe_n, !i[0]);
      end
      loop_mode_select <= 0;
      acc(1, 4'h0, 8'h04);
      chk(rxd_port_owned, 0);
      b <= $urandom;
      go <= 1;
      tick(1);
      go <= 0;
      for (i = 0; i < 10; i++) begin
         k = 0;
         do begin
            @(posedge ref_clk);
            k++;
         end while (!mid && k < 40);
         if (k == 40) begin
            num_errors++;
            test_done;
         end
         chk(rx_serial, rxd_pin_in);
         chk(rx_serial, ({1'b1, b, 1'b0} >> i) & 1);
      end
      acc(1, 4'h0, 8'h00);
      tick(3); chk(rx_serial, 1);
      chk(rxd_port_owned, 1);
      test_done;
   end
endmodule // uctl_top_bench
